// file: core/rdc_chain.sv
// Real-time clock chain: source select, two prescalers, 16-bit timer, 32-bit four-field count.
// Assumes all inputs synchronous to clock; reset_n is the power reset and nothing else.
`default_nettype none
module rdc_chain #(
  parameter int TIMER_W = rdc_pkg::TIMER_W
) (
  // Clock and power reset
  input wire logic clock,
  input wire logic reset_n,
  // Clock source and prescalers
  input wire logic [1:0] source_sel,
  input wire logic int_tick_a,
  input wire logic int_tick_b,
  input wire logic ext_clock_pin,
  input wire logic div32_on,
  input wire logic div8_on,
  // 16-bit timer
  input wire logic [TIMER_W-1:0] timer_reload,
  input wire logic timer_write,
  input wire logic [TIMER_W-1:0] timer_wdata,
  // Field reload values
  input wire logic [rdc_pkg::FIELD0_W-1:0] field0_reload,
  input wire logic [rdc_pkg::FIELD1_W-1:0] field1_reload,
  input wire logic [rdc_pkg::FIELD2_W-1:0] field2_reload,
  input wire logic [rdc_pkg::FIELD3_W-1:0] field3_reload,
  // Half-word access to the 32-bit count
  input wire logic count_low_write,
  input wire logic count_high_write,
  input wire logic [rdc_pkg::HALF_W-1:0] count_wdata,
  output logic [rdc_pkg::HALF_W-1:0] clock_count_low_half,
  output logic [rdc_pkg::HALF_W-1:0] clock_count_high_half,
  output logic [TIMER_W+rdc_pkg::COUNT_W-1:0] count48,
  // Alarm
  input wire logic alarm_on,
  input wire logic [rdc_pkg::COUNT_W-1:0] alarm_time,
  // Requests
  input wire logic [rdc_pkg::FLAG_N-1:0] request_enable,
  input wire logic [rdc_pkg::FLAG_N-1:0] request_clear,
  output logic [rdc_pkg::FLAG_N-1:0] request_flags,
  output logic node_request
);
  logic pin_prev;
  logic pin_edge;
  logic source_pulse;
  logic [rdc_pkg::DIV_A_W-1:0] div32_count;
  logic div32_out;
  logic [rdc_pkg::DIV_B_W-1:0] div8_count;
  logic div8_out;
  logic timer_carry;
  logic [TIMER_W-1:0] prescale_reload_timer;
  logic [rdc_pkg::FIELD0_W-1:0] field0;
  logic [rdc_pkg::FIELD1_W-1:0] field1;
  logic [rdc_pkg::FIELD2_W-1:0] field2;
  logic [rdc_pkg::FIELD3_W-1:0] field3;
  logic [3:0] field_carry;
  logic [rdc_pkg::COUNT_W-1:0] count32;
  logic alarm_match;
  logic alarm_prev;
  logic [rdc_pkg::FLAG_N-1:0] events;

  // Rising edges of the external clock pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= ext_clock_pin;
    end
  end
  assign pin_edge = ext_clock_pin && !pin_prev;

  // Source select; internal ticks keep the count free of the processor rate
  always_comb begin
    case (rdc_pkg::rdc_source_e'(source_sel))
      rdc_pkg::RDC_SRC_INT_A: source_pulse = int_tick_a; // RULE_01
      rdc_pkg::RDC_SRC_INT_B: source_pulse = int_tick_b; // RULE_01
      rdc_pkg::RDC_SRC_PIN: source_pulse = pin_edge; // RULE_01
      default: source_pulse = 1'b0;
    endcase
  end

  // Divide-by-32 stage, bypassed when off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div32_count <= '0;
    end else if (source_pulse && div32_on) begin
      div32_count <= div32_count + 1'b1; // RULE_02
    end
  end
  assign div32_out = div32_on ? (source_pulse && div32_count == rdc_pkg::DIV_A_LAST) : source_pulse; // RULE_02

  // Divide-by-8 stage, bypassed when off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div8_count <= '0;
    end else if (div32_out && div8_on) begin
      div8_count <= div8_count + 1'b1; // RULE_02
    end
  end
  assign div8_out = div8_on ? (div32_out && div8_count == rdc_pkg::DIV_B_LAST) : div32_out; // RULE_02

  // 16-bit reloadable timer after the prescalers
  rdc_stage #(.W(TIMER_W)) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .step(div8_out), // RULE_03
    .reload(timer_reload),
    .load(timer_write),
    .load_value(timer_wdata),
    .value(prescale_reload_timer),
    .carry(timer_carry)
  );

  // Four cascaded fields; each carry steps the next one
  rdc_stage #(.W(rdc_pkg::FIELD0_W)) u_field0 (
    .clock(clock),
    .reset_n(reset_n),
    .step(timer_carry), // RULE_03
    .reload(field0_reload),
    .load(count_low_write),
    .load_value(count_wdata[rdc_pkg::FIELD0_W-1:0]),
    .value(field0),
    .carry(field_carry[0])
  );
  rdc_stage #(.W(rdc_pkg::FIELD1_W)) u_field1 (
    .clock(clock),
    .reset_n(reset_n),
    .step(field_carry[0]), // RULE_04
    .reload(field1_reload),
    .load(count_low_write),
    .load_value(count_wdata[rdc_pkg::HALF_W-1:rdc_pkg::FIELD0_W]),
    .value(field1),
    .carry(field_carry[1])
  );
  rdc_stage #(.W(rdc_pkg::FIELD2_W)) u_field2 (
    .clock(clock),
    .reset_n(reset_n),
    .step(field_carry[1]), // RULE_04
    .reload(field2_reload),
    .load(count_high_write),
    .load_value(count_wdata[rdc_pkg::FIELD2_W-1:0]),
    .value(field2),
    .carry(field_carry[2])
  );
  rdc_stage #(.W(rdc_pkg::FIELD3_W)) u_field3 (
    .clock(clock),
    .reset_n(reset_n),
    .step(field_carry[2]), // RULE_04
    .reload(field3_reload),
    .load(count_high_write),
    .load_value(count_wdata[rdc_pkg::HALF_W-1:rdc_pkg::FIELD2_W]),
    .value(field3),
    .carry(field_carry[3])
  );

  // Read views: halves, whole 32 bits and the 48-bit long count
  assign count32 = {field3, field2, field1, field0}; // RULE_04
  assign clock_count_low_half = count32[rdc_pkg::HALF_W-1:0]; // RULE_04
  assign clock_count_high_half = count32[rdc_pkg::COUNT_W-1:rdc_pkg::HALF_W]; // RULE_04
  assign count48 = {count32, prescale_reload_timer}; // RULE_08

  // Alarm fires once as the count arrives at the chosen time
  assign alarm_match = alarm_on && count32 == alarm_time; // RULE_09
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_prev <= 1'b0;
    end else begin
      alarm_prev <= alarm_match;
    end
  end

  assign events = {alarm_match && !alarm_prev, field_carry, timer_carry}; // RULE_10

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      request_flags <= rdc_pkg::FLAG_RESET; // RULE_07
    end else begin
      request_flags <= (request_flags & ~request_clear) | events; // RULE_05
    end
  end

  // One common node request for all enabled stages
  assign node_request = |(request_flags & request_enable); // RULE_06

  sequence s_timer_wrap;
    timer_carry;
  endsequence
  sequence s_field0_moved;
    ##1 field0 != $past(field0) || $past(count_low_write);
  endsequence
  property p_carry_into_field;
    @(posedge clock) disable iff (!reset_n) s_timer_wrap |-> s_field0_moved;
  endproperty
  a_carry_into_field: assert property (p_carry_into_field) else $error("timer overflow did not step field"); // RULE_03

  property p_flag_set;
    @(posedge clock) disable iff (!reset_n) events[rdc_pkg::FLAG_TIMER] |=> request_flags[rdc_pkg::FLAG_TIMER];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag lost"); // RULE_10

  property p_field_flag;
    @(posedge clock) disable iff (!reset_n) field_carry[0] |=> request_flags[rdc_pkg::FLAG_FIELD0];
  endproperty
  a_field_flag: assert property (p_field_flag) else $error("field overflow flag lost"); // RULE_05

  property p_node;
    @(posedge clock) disable iff (!reset_n) node_request == |(request_flags & request_enable);
  endproperty
  a_node: assert property (p_node) else $error("node request mismatch"); // RULE_06

  property p_div32_ratio;
    @(posedge clock) disable iff (!reset_n) (div32_on && div32_out) |-> div32_count == rdc_pkg::DIV_A_LAST;
  endproperty
  a_div32_ratio: assert property (p_div32_ratio) else $error("divide-by-32 out of step"); // RULE_02

  property p_div8_bypass;
    @(posedge clock) disable iff (!reset_n) !div8_on |-> div8_out == div32_out;
  endproperty
  a_div8_bypass: assert property (p_div8_bypass) else $error("divide-by-8 bypass broken"); // RULE_02

  property p_alarm;
    @(posedge clock) disable iff (!reset_n) $rose(alarm_match) |=> request_flags[rdc_pkg::FLAG_ALARM];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm request missing"); // RULE_09

  property p_long_count;
    @(posedge clock) disable iff (!reset_n) count48[TIMER_W-1:0] == prescale_reload_timer && count48[TIMER_W] == field0[0];
  endproperty
  a_long_count: assert property (p_long_count) else $error("48-bit view misassembled"); // RULE_08

  property p_flag_sticky;
    @(posedge clock) disable iff (!reset_n)
      (request_flags[rdc_pkg::FLAG_ALARM] && !request_clear[rdc_pkg::FLAG_ALARM]) |=> request_flags[rdc_pkg::FLAG_ALARM];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // RULE_05
endmodule : rdc_chain
`default_nettype wire

// file: core/rdc_pkg.sv
// Constants of the real-time clock divider chain: widths, ratios, source codes, flag positions.
// Assumes one 100 MHz clock and a power-on reset that alone clears the chain.
// Summary of operation
// [RULE_01] Software picks the count clock: internal source or external pin edges.
// [RULE_02] Divide-by-32 and divide-by-8 prescalers, each switched in or bypassed.
// [RULE_03] A 16-bit reloadable timer follows; its overflow drives the 32-bit block.
// [RULE_04] 32-bit count of 10, 6, 6, 10-bit reloadable fields, two 16-bit halves.
// [RULE_05] Every stage counts up only and can raise its own request.
// [RULE_06] All enabled requests merge onto one common node request.
// [RULE_07] Only the power reset clears the chain; other resets leave it alone.
// [RULE_08] The 16-bit timer and 32-bit block read as one 48-bit count.
// [RULE_09] Alarm request at a chosen count; periodic tick independent of processor clock.
// [RULE_10] On overflow a stage reloads, carries one count onward and flags its request.
`default_nettype none
package rdc_pkg;
  localparam int CLOCK_MHZ = 100;
  localparam int TIMER_W = 16;
  localparam int FIELD0_W = 10;
  localparam int FIELD1_W = 6;
  localparam int FIELD2_W = 6;
  localparam int FIELD3_W = 10;
  localparam int COUNT_W = FIELD0_W + FIELD1_W + FIELD2_W + FIELD3_W;
  localparam int HALF_W = 16;
  localparam int DIV_A_W = 5;
  localparam logic [DIV_A_W-1:0] DIV_A_LAST = 5'h1f; // 32:1
  localparam int DIV_B_W = 3;
  localparam logic [DIV_B_W-1:0] DIV_B_LAST = 3'h7; // 8:1
  localparam int FLAG_N = 6;
  localparam int FLAG_TIMER = 0;
  localparam int FLAG_FIELD0 = 1;
  localparam int FLAG_ALARM = 5;
  localparam logic [FLAG_N-1:0] FLAG_RESET = 6'h00;
  typedef enum logic [1:0] {
    RDC_SRC_INT_A,
    RDC_SRC_INT_B,
    RDC_SRC_PIN,
    RDC_SRC_OFF
  } rdc_source_e;
endpackage : rdc_pkg
`default_nettype wire

// file: core/rdc_stage.sv
// One reloadable count-up stage of the chain, width set by parameter.
// Assumes step is a one-cycle enable and load a one-cycle software write.
`default_nettype none
module rdc_stage #(
  parameter int W = 16
) (
  // Clock and power reset
  input wire logic clock,
  input wire logic reset_n,
  // Count control
  input wire logic step,
  input wire logic [W-1:0] reload,
  // Software write
  input wire logic load,
  input wire logic [W-1:0] load_value,
  // State and overflow
  output logic [W-1:0] value,
  output logic carry
);
  function automatic logic all_ones(input logic [W-1:0] v);
    return &v;
  endfunction : all_ones

  // Overflow is the step that leaves the all-ones state
  assign carry = step && all_ones(value) && !load; // RULE_10

  // Write beats a step so software never sees a half-applied value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0; // RULE_07
    end else if (load) begin
      value <= load_value;
    end else if (carry) begin
      value <= reload; // RULE_10
    end else if (step) begin
      value <= value + 1'b1; // RULE_05
    end
  end

  property p_stage_reload;
    @(posedge clock) disable iff (!reset_n) carry |=> value == $past(reload);
  endproperty
  a_stage_reload: assert property (p_stage_reload) else $error("stage did not reload on overflow"); // RULE_10

  property p_stage_up;
    @(posedge clock) disable iff (!reset_n) (step && !load && !all_ones(value)) |=> value == $past(value) + 1'b1;
  endproperty
  a_stage_up: assert property (p_stage_up) else $error("stage did not count up"); // RULE_05

  property p_stage_hold;
    @(posedge clock) disable iff (!reset_n) (!step && !load) |=> $stable(value);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("stage moved without a step"); // RULE_05

  property p_stage_load;
    @(posedge clock) disable iff (!reset_n) load |=> value == $past(load_value);
  endproperty
  a_stage_load: assert property (p_stage_load) else $error("software write lost"); // RULE_04
endmodule : rdc_stage
`default_nettype wire

// file: verification/test_rdc_chain.sv
// Self-checking bench for the real-time clock divider chain: sources, prescalers, overflow ripple, alarm, reset.
// Assumes the chain's ports as declared in rdc_chain and drives them directly, with no partner model.
`default_nettype none
`define CHK(got, want) begin n_checks++; if ((got) !== (want)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module test_rdc_chain;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] source_sel = 2'h0;
  logic int_tick_a = 1'b0, int_tick_b = 1'b0, ext_clock_pin = 1'b0, div32_on = 1'b0, div8_on = 1'b0;
  logic [15:0] timer_reload = 16'h0000, timer_wdata = 16'h0000, count_wdata = 16'h0000;
  logic timer_write = 1'b0, count_low_write = 1'b0, count_high_write = 1'b0, alarm_on = 1'b0;
  logic [9:0] field0_reload = 10'h005, field3_reload = 10'h001;
  logic [5:0] field1_reload = 6'h03, field2_reload = 6'h02;
  logic [31:0] alarm_time = 32'h0000_0000;
  logic [5:0] request_enable = 6'h00, request_clear = 6'h00, request_flags;
  logic [15:0] clock_count_low_half, clock_count_high_half;
  logic [47:0] count48;
  logic node_request;
  int n_mismatch = 0;
  int n_checks = 0;
  // 100 MHz clock
  always #5 clock = ~clock;
  rdc_chain rdc_chain_i (.clock(clock), .reset_n(reset_n), .source_sel(source_sel), .int_tick_a(int_tick_a),
    .int_tick_b(int_tick_b), .ext_clock_pin(ext_clock_pin), .div32_on(div32_on), .div8_on(div8_on),
    .timer_reload(timer_reload), .timer_write(timer_write), .timer_wdata(timer_wdata),
    .field0_reload(field0_reload), .field1_reload(field1_reload), .field2_reload(field2_reload),
    .field3_reload(field3_reload), .count_low_write(count_low_write), .count_high_write(count_high_write),
    .count_wdata(count_wdata), .clock_count_low_half(clock_count_low_half),
    .clock_count_high_half(clock_count_high_half), .count48(count48), .alarm_on(alarm_on),
    .alarm_time(alarm_time), .request_enable(request_enable), .request_clear(request_clear),
    .request_flags(request_flags), .node_request(node_request));
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // One count per pulse pair; the spare cycle lets a registered pin edge detector land too
  task automatic pulse(input logic [2:0] which, input int n);
    repeat (n) begin
      @(posedge clock) {ext_clock_pin, int_tick_b, int_tick_a} <= which;
      @(posedge clock) {ext_clock_pin, int_tick_b, int_tick_a} <= 3'h0;
    end
    @(posedge clock);
    @(negedge clock);
  endtask : pulse
  // Software write: 0 timer, 1 low half, 2 high half
  task automatic wr(input int which, input logic [15:0] data);
    @(posedge clock);
    timer_wdata <= data;
    count_wdata <= data;
    timer_write <= (which == 0);
    count_low_write <= (which == 1);
    count_high_write <= (which == 2);
    @(posedge clock) {timer_write, count_low_write, count_high_write} <= 3'h0;
    @(negedge clock);
  endtask : wr
  task automatic check_cleared;
    `CHK(count48, 48'h0000_0000_0000)
    `CHK(request_flags, 6'h00)
    `CHK(node_request, 1'b0)
  endtask : check_cleared
  // Each source counts only when selected; off counts nothing
  task automatic t_sources;
    pulse(3'h1, 3);
    `CHK(count48[15:0], 16'h0003)
    @(posedge clock) source_sel <= 2'h1;
    pulse(3'h1, 2);
    pulse(3'h2, 2);
    `CHK(count48[15:0], 16'h0005)
    @(posedge clock) source_sel <= 2'h2;
    pulse(3'h4, 4);
    `CHK(count48[15:0], 16'h0009)
    @(posedge clock) source_sel <= 2'h3;
    pulse(3'h7, 3);
    `CHK(count48[15:0], 16'h0009)
  endtask : t_sources
  // Prescalers pass every 8th, 32nd and, in series, 256th pulse
  task automatic t_prescale;
    @(posedge clock) source_sel <= 2'h0;
    div8_on <= 1'b1;
    pulse(3'h1, 7);
    `CHK(count48[15:0], 16'h0009)
    pulse(3'h1, 1);
    `CHK(count48[15:0], 16'h000a)
    @(posedge clock) div8_on <= 1'b0;
    div32_on <= 1'b1;
    pulse(3'h1, 31);
    `CHK(count48[15:0], 16'h000a)
    pulse(3'h1, 1);
    `CHK(count48[15:0], 16'h000b)
    @(posedge clock) div8_on <= 1'b1;
    pulse(3'h1, 255);
    `CHK(count48[15:0], 16'h000b)
    pulse(3'h1, 1);
    `CHK(count48[15:0], 16'h000c)
    @(posedge clock) {div8_on, div32_on} <= 2'h0;
  endtask : t_prescale
  // Timer overflow reloads, steps field0, flags and reaches the node only when enabled
  task automatic t_overflow;
    @(posedge clock) timer_reload <= 16'h0100;
    request_enable <= 6'h01;
    wr(1, 16'h0000);
    wr(2, 16'h0000);
    wr(0, 16'hffff);
    pulse(3'h1, 1);
    `CHK(count48, 48'h0000_0001_0100)
    `CHK(request_flags, 6'h01)
    `CHK(node_request, 1'b1)
    @(posedge clock) request_enable <= 6'h3e;
    @(negedge clock);
    `CHK(node_request, 1'b0)
    @(posedge clock) request_clear <= 6'h3f;
    @(negedge clock);
    @(posedge clock) request_clear <= 6'h00;
    @(negedge clock);
    `CHK(request_flags, 6'h00)
  endtask : t_overflow
  // Full ripple through all four fields in one step, as one 48-bit count
  task automatic t_ripple;
    wr(1, 16'h1234);
    `CHK(clock_count_low_half, 16'h1234)
    wr(1, 16'hffff);
    wr(2, 16'hffff);
    wr(0, 16'hffff);
    `CHK(count48, 48'hffff_ffff_ffff)
    pulse(3'h1, 1);
    `CHK(clock_count_low_half, 16'h0c05)
    `CHK(clock_count_high_half, 16'h0042)
    `CHK(count48, 48'h0042_0c05_0100)
    `CHK(request_flags, 6'h1f)
    `CHK(node_request, 1'b1)
  endtask : t_ripple
  // Alarm flag one cycle after the count arrives at the chosen time
  task automatic t_alarm;
    @(posedge clock) request_clear <= 6'h3f;
    wr(2, 16'h0000);
    wr(1, 16'h0002);
    wr(0, 16'hffff);
    @(posedge clock) alarm_time <= 32'h0000_0003;
    alarm_on <= 1'b1;
    request_enable <= 6'h20;
    request_clear <= 6'h00;
    @(negedge clock);
    `CHK(request_flags[5], 1'b0)
    pulse(3'h1, 1);
    `CHK(clock_count_low_half, 16'h0003)
    `CHK(request_flags[5], 1'b1)
    `CHK(node_request, 1'b1)
  endtask : t_alarm
  // Watchdog on the whole run
  initial begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clock);
    check_cleared();
    reset_n <= 1'b1;
    @(negedge clock);
    check_cleared();
    t_sources();
    t_prescale();
    t_overflow();
    t_ripple();
    t_alarm();
    // Power reset in mid-run clears everything again
    @(posedge clock) reset_n <= 1'b0;
    @(negedge clock);
    check_cleared();
    test_done();
  end
endmodule : test_rdc_chain
`default_nettype wire
